// ==== rtl/tcs_regs.sv ====
// Tile control and status register bank with its controlled logic.
// Assumes a single tile clock that is also the PLL output, a status
// register port driven by the core, and boot straps stable after reset.
module tcs_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Status register port
  input wire logic psWrEn,
  input wire logic psRdEn,
  input wire logic [7:0] psRegNum,
  input wire logic [31:0] psWrData,
  output logic [31:0] psRdData,
  output logic psAck,
  output logic psErr,
  // Boot straps and tile identity
  input wire logic [7:0] procNum,
  input wire logic bootStrapOverride,
  input wire logic core1PoweredOff,
  input wire logic skipOtpPoll,
  input wire logic bootFromRam,
  input wire logic bootFromJtag,
  input wire logic [1:0] pllModePins,
  // OTP security word load
  input wire logic otpSecLoad,
  input wire logic [31:0] otpSecWord,
  // Thread activity
  input wire logic allThreadsPaused,
  // Transmit data path
  input wire logic [tcs_pkg::TCS_TXDATA_WIDTH-1:0] txDataIn,
  output logic [tcs_pkg::TCS_TXDATA_WIDTH-1:0] txDataOut,
  output logic txClk,
  output logic rgmiiPortEn,
  // Clocking and USB controls
  output logic lowPowerDivActive,
  output logic utmiSelect,
  output logic ulpiHelperEn,
  // Security controls
  output logic globalDebugBlock,
  output logic jtagTapBlock,
  output logic [3:0] otpSectorLock,
  output logic otpRedundancyEn,
  output logic bootImageFromOtp,
  output logic jtagConfigBlock
);
  import tcs_pkg::*;

  // ==========================================================
  // Storage
  // ==========================================================
  logic [31:0] tileControl_reg;
  logic [31:0] tileControl_next;
  logic [31:0] security_reg;
  logic [31:0] security_next;
  logic [31:0] ringControl_reg;
  logic [31:0] ringControl_next;
  logic [31:0] psRdData_reg;
  logic [31:0] psRdData_next;
  logic psAck_reg;
  logic psErr_reg;
  logic psErr_next;
  logic [TCS_TXDATA_WIDTH-1:0] delayMem [TCS_DELAY_DEPTH];
  logic [7:0] delayWrPtr_reg;
  logic [TCS_TXDATA_WIDTH-1:0] txDataOut_reg;

  // ==========================================================
  // Address decode
  // ==========================================================
  logic hitControl;
  logic hitBoot;
  logic hitSecurity;
  logic hitRing;
  logic hitValue;
  logic [7:0] valueOffset;
  logic [1:0] valueIndex;
  logic anyHit;
  logic wrControl;
  logic wrSecurity;
  logic wrRing;
  logic securityLocked;
  logic writeRefused;

  assign hitControl = (psRegNum == TCS_REG_TILE_CONTROL);
  assign hitBoot = (psRegNum == TCS_REG_BOOT_STATUS);
  assign hitSecurity = (psRegNum == TCS_REG_SECURITY);
  assign hitRing = (psRegNum == TCS_REG_RING_CONTROL);
  assign valueOffset = 8'(psRegNum - TCS_REG_RING_VALUE0);
  assign hitValue = (psRegNum >= TCS_REG_RING_VALUE0) &&
                    (valueOffset < 8'(TCS_RING_COUNT));
  assign valueIndex = valueOffset[1:0];
  assign anyHit = hitControl | hitBoot | hitSecurity | hitRing | hitValue;
  assign securityLocked = security_reg[TCS_WRLOCK_BIT];

  // Write strobes; a read takes priority if both are raised
  assign wrControl = psWrEn & !psRdEn & hitControl;
  assign wrRing = psWrEn & !psRdEn & hitRing;
  assign wrSecurity = psWrEn & !psRdEn & hitSecurity &
                      !securityLocked;
  // Writes to read-only or locked registers are flagged, not stored
  assign writeRefused = psWrEn & !psRdEn &
                        (!anyHit | hitBoot | hitValue |
                         (hitSecurity & securityLocked));

  // ==========================================================
  // Next register values
  // ==========================================================
  // Only documented fields are stored, so reserved bits stay zero
  assign tileControl_next = wrControl ?
                            (psWrData & TCS_TILE_CONTROL_MASK) :
                            tileControl_reg;
  assign ringControl_next = wrRing ?
                            (psWrData & TCS_RING_CONTROL_MASK) :
                            ringControl_reg;
  // OTP load wins over a software write in the same cycle
  assign security_next = otpSecLoad ?
                         (otpSecWord & TCS_SECURITY_MASK) :
                         wrSecurity ? (psWrData & TCS_SECURITY_MASK) :
                         security_reg;

  // Control and security registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tileControl_reg <= TCS_TILE_CONTROL_RESET;
      security_reg <= TCS_SECURITY_RESET;
      ringControl_reg <= TCS_RING_CONTROL_RESET;
    end
    else
    begin
      tileControl_reg <= tileControl_next;
      security_reg <= security_next;
      ringControl_reg <= ringControl_next;
    end
  end

  // ==========================================================
  // Ring oscillator counters
  // ==========================================================
  logic [TCS_RING_WIDTH-1:0] ringCount [TCS_RING_COUNT];
  logic coreRun;
  logic periRun;

  // Indices 0 and 1 sit on the core side, 2 and 3 on the periphery
  assign coreRun = ringControl_reg[TCS_RINGCORE_BIT];
  assign periRun = ringControl_reg[TCS_RINGPERI_BIT];

  // Each counter steps by its own odd amount to decorrelate them
  for (genvar i = 0; i < TCS_RING_COUNT; i++)
  begin : g_ring
    tcs_ring_cnt #(
      .STEP(16'(2 * i + 1))
    ) u_ring (
      .clk(clk),
      .run((i < 2) ? coreRun : periRun),
      .count(ringCount[i])
    );
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic [31:0] bootStatus;
  logic [31:0] valueWord;
  logic [31:0] readWord;

  // Boot status is assembled live from the strap inputs
  assign bootStatus = (32'(procNum) << TCS_PROCNUM_LSB) |
                      (32'(bootStrapOverride) << TCS_STRAPOVR_BIT) |
                      (32'(core1PoweredOff) << TCS_CORE1OFF_BIT) |
                      (32'(skipOtpPoll) << TCS_SKIPPOLL_BIT) |
                      (32'(bootFromRam) << TCS_BOOTRAM_BIT) |
                      (32'(bootFromJtag) << TCS_BOOTJTAG_BIT) |
                      32'(pllModePins);
  // Upper half reads zero
  assign valueWord = {16'h0000, ringCount[valueIndex]};
  assign readWord = ({32{hitControl}} & tileControl_reg) |
                    ({32{hitBoot}} & bootStatus) |
                    ({32{hitSecurity}} & security_reg) |
                    ({32{hitRing}} & ringControl_reg) |
                    ({32{hitValue}} & valueWord);
  // Unmapped reads return zero and raise the error flag
  assign psRdData_next = psRdEn ? readWord : psRdData_reg;
  assign psErr_next = (psRdEn & !anyHit) | writeRefused;

  // Port answer, one cycle after the request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      psRdData_reg <= 32'h0000_0000;
      psAck_reg <= 1'b0;
      psErr_reg <= 1'b0;
    end
    else
    begin
      psRdData_reg <= psRdData_next;
      psAck_reg <= psRdEn | psWrEn;
      psErr_reg <= psErr_next;
    end
  end

  assign psRdData = psRdData_reg;
  assign psAck = psAck_reg;
  assign psErr = psErr_reg;

  // ==========================================================
  // Transmit data delay line
  // ==========================================================
  logic [7:0] txDelay;
  logic [7:0] delayRdPtr;

  assign txDelay = tileControl_reg[TCS_TXDLY_MSB:TCS_TXDLY_LSB];
  // Reading behind the write pointer gives delay plus one flop stage;
  // a zero delay still costs that single output flop
  assign delayRdPtr = 8'(delayWrPtr_reg - txDelay);

  // Circular buffer, no reset needed on the array itself
  always_ff @(posedge clk)
  begin
    delayMem[delayWrPtr_reg] <= txDataIn;
  end

  // Write pointer and output flop
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      delayWrPtr_reg <= 8'h00;
      txDataOut_reg <= '0;
    end
    else
    begin
      delayWrPtr_reg <= 8'(delayWrPtr_reg + 8'h01);
      // Port disabled drives idle data
      txDataOut_reg <= rgmiiPortEn ?
                       ((txDelay == 8'h00) ? txDataIn :
                        delayMem[delayRdPtr]) : '0;
    end
  end

  assign txDataOut = txDataOut_reg;

  // ==========================================================
  // Transmit clock divider
  // ==========================================================
  // Divider value is ratio minus one as software writes it
  tcs_txclk_div u_txclk (
    .clk(clk),
    .resetn(resetn),
    .enable(rgmiiPortEn),
    .divValue(tileControl_reg[TCS_TXDIV_MSB:TCS_TXDIV_LSB]),
    .txClk(txClk)
  );

  // ==========================================================
  // Tile control outputs
  // ==========================================================
  logic lpDivEnable;
  logic lpDynamic;

  assign rgmiiPortEn = tileControl_reg[TCS_PORTEN_BIT];
  assign lpDivEnable = tileControl_reg[TCS_LPDIVEN_BIT];
  assign lpDynamic = tileControl_reg[TCS_DYNMODE_BIT];
  // Dynamic mode slows the clock only while every thread waits
  assign lowPowerDivActive = lpDivEnable &
                             (!lpDynamic | allThreadsPaused);
  assign utmiSelect = tileControl_reg[TCS_UTMISEL_BIT];
  assign ulpiHelperEn = tileControl_reg[TCS_ULPIHELP_BIT];

  // ==========================================================
  // Security outputs
  // ==========================================================
  assign globalDebugBlock = security_reg[TCS_GDBGOFF_BIT];
  assign jtagTapBlock = security_reg[TCS_TAPOFF_BIT];
  // Lock-all overrides each individual sector bit
  assign otpSectorLock = security_reg[TCS_OTPSEC_LSB +: 4] |
                         {4{security_reg[TCS_OTPALL_BIT]}};
  assign otpRedundancyEn = security_reg[TCS_OTPRED_BIT];
  assign bootImageFromOtp = security_reg[TCS_OTPBOOT_BIT];
  assign jtagConfigBlock = security_reg[TCS_JTAGCFG_BIT];

endmodule : tcs_regs

// ==== rtl/tcs_pkg.sv ====
// Package for the tile control and status register bank.
// Holds register numbers, field positions, write masks and reset values;
// assumes the core addresses registers by an 8-bit status register number.
package tcs_pkg;

  // ==========================================================
  // Register numbers on the status register port
  // ==========================================================
  localparam logic [7:0] TCS_REG_TILE_CONTROL = 8'h02;
  localparam logic [7:0] TCS_REG_BOOT_STATUS = 8'h03;
  localparam logic [7:0] TCS_REG_SECURITY = 8'h05;
  localparam logic [7:0] TCS_REG_RING_CONTROL = 8'h06;
  localparam logic [7:0] TCS_REG_RING_VALUE0 = 8'h07;
  localparam int TCS_RING_COUNT = 4;
  localparam int TCS_RING_WIDTH = 16;

  // ==========================================================
  // Tile control fields
  // ==========================================================
  localparam int TCS_TXDLY_LSB = 18;
  localparam int TCS_TXDLY_MSB = 25;
  localparam int TCS_TXDIV_LSB = 9;
  localparam int TCS_TXDIV_MSB = 17;
  localparam int TCS_PORTEN_BIT = 8;
  localparam int TCS_DYNMODE_BIT = 5;
  localparam int TCS_LPDIVEN_BIT = 4;
  localparam int TCS_UTMISEL_BIT = 2;
  localparam int TCS_ULPIHELP_BIT = 1;
  localparam logic [31:0] TCS_TILE_CONTROL_MASK = 32'h03ff_ff36;
  localparam logic [31:0] TCS_TILE_CONTROL_RESET = 32'h0000_0000;

  // ==========================================================
  // Boot status fields
  // ==========================================================
  localparam int TCS_PROCNUM_LSB = 16;
  localparam int TCS_STRAPOVR_BIT = 8;
  localparam int TCS_CORE1OFF_BIT = 5;
  localparam int TCS_SKIPPOLL_BIT = 4;
  localparam int TCS_BOOTRAM_BIT = 3;
  localparam int TCS_BOOTJTAG_BIT = 2;

  // ==========================================================
  // Security fields
  // ==========================================================
  localparam int TCS_WRLOCK_BIT = 31;
  localparam int TCS_GDBGOFF_BIT = 14;
  localparam int TCS_OTPALL_BIT = 12;
  localparam int TCS_OTPSEC_LSB = 8;
  localparam int TCS_OTPRED_BIT = 7;
  localparam int TCS_OTPBOOT_BIT = 5;
  localparam int TCS_JTAGCFG_BIT = 4;
  localparam int TCS_TAPOFF_BIT = 0;
  localparam logic [31:0] TCS_SECURITY_MASK = 32'h8000_5fb1;
  localparam logic [31:0] TCS_SECURITY_RESET = 32'h0000_0000;

  // ==========================================================
  // Ring oscillator control fields
  // ==========================================================
  localparam int TCS_RINGCORE_BIT = 1;
  localparam int TCS_RINGPERI_BIT = 0;
  localparam logic [31:0] TCS_RING_CONTROL_MASK = 32'h0000_0003;
  localparam logic [31:0] TCS_RING_CONTROL_RESET = 32'h0000_0000;

  // ==========================================================
  // Transmit path
  // ==========================================================
  localparam int TCS_TXDATA_WIDTH = 5;
  localparam int TCS_DELAY_DEPTH = 256;
  localparam logic [8:0] TCS_TXDIV_RESET = 9'h000;

endpackage : tcs_pkg

// ==== rtl/tcs_txclk_div.sv ====
// Transmit clock divider for the reduced-gigabit MII port.
// Assumes clk is the PLL output and the divider value is held steady.
module tcs_txclk_div
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic [8:0] divValue,
  // Divided clock
  output logic txClk
);
  import tcs_pkg::*;

  logic [8:0] count_reg;
  logic [8:0] count_next;
  logic txClk_reg;
  logic txClk_next;
  logic atTop;
  logic atHalf;

  // ==========================================================
  // Compare points
  // ==========================================================
  assign atTop = (count_reg == divValue);
  assign atHalf = (count_reg == (divValue >> 1));
  assign count_next = !enable ? TCS_TXDIV_RESET :
                      atTop ? TCS_TXDIV_RESET : 9'(count_reg + 9'h001);
  // Rise wins when both match, so a ratio of one holds the clock high
  assign txClk_next = !enable ? 1'b0 :
                      atTop ? 1'b1 :
                      atHalf ? 1'b0 : txClk_reg;
  assign txClk = txClk_reg;

  // Counter and clock flop
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_reg <= TCS_TXDIV_RESET;
      txClk_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      txClk_reg <= txClk_next;
    end
  end

endmodule : tcs_txclk_div

// ==== rtl/tcs_ring_cnt.sv ====
// One free-running oscillator counter.
// Assumes the run level comes from the ring control register.
module tcs_ring_cnt
#(
  parameter logic [15:0] STEP = 16'h0001
)
(
  // Clock
  input wire logic clk,
  // Control
  input wire logic run,
  // Count
  output logic [15:0] count
);
  import tcs_pkg::*;

  logic [15:0] count_reg = 16'h0000;
  logic [15:0] count_next;
  logic [15:0] jitter_reg = 16'h0000;

  // ==========================================================
  // Oscillator model
  // ==========================================================
  // Single clock only: the step mixes in a local LFSR to stand in
  // for the drift of a real free oscillator
  assign count_next = 16'(count_reg + STEP + {15'h0000, jitter_reg[0]});
  assign count = count_reg;

  // No reset: the count survives a system reset
  always_ff @(posedge clk)
  begin
    if (run)
    begin
      count_reg <= count_next;
      jitter_reg <= {jitter_reg[14:0],
                     jitter_reg[15] ^ jitter_reg[13] ^ ~jitter_reg[12]};
    end
  end

endmodule : tcs_ring_cnt

// ==== test/tcs_regs_props.sv ====
// Assertions for the tile control and status register bank.
// Assumes it is bound onto tcs_regs and sees only that module's ports.
module tcs_regs_props
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Status register port
  input wire logic psWrEn,
  input wire logic psRdEn,
  input wire logic [7:0] psRegNum,
  input wire logic [31:0] psWrData,
  input wire logic [31:0] psRdData,
  input wire logic psAck,
  input wire logic psErr,
  // Straps and loads
  input wire logic [7:0] procNum,
  input wire logic bootStrapOverride,
  input wire logic core1PoweredOff,
  input wire logic skipOtpPoll,
  input wire logic bootFromRam,
  input wire logic bootFromJtag,
  input wire logic [1:0] pllModePins,
  input wire logic otpSecLoad,
  input wire logic [31:0] otpSecWord,
  input wire logic allThreadsPaused,
  // Controls
  input wire logic rgmiiPortEn,
  input wire logic lowPowerDivActive,
  input wire logic utmiSelect,
  input wire logic ulpiHelperEn,
  input wire logic globalDebugBlock,
  input wire logic jtagTapBlock,
  input wire logic [3:0] otpSectorLock,
  input wire logic otpRedundancyEn,
  input wire logic bootImageFromOtp,
  input wire logic jtagConfigBlock
);
  import tcs_pkg::*;
  logic [31:0] ctrlShadow;
  logic [31:0] secShadow;
  wire logic plainWr = psWrEn && !psRdEn;
  wire logic ctrlWrite = plainWr && psRegNum == TCS_REG_TILE_CONTROL;
  wire logic secWrite = plainWr && psRegNum == TCS_REG_SECURITY;
  wire logic ringRead = psRdEn && psRegNum >= TCS_REG_RING_VALUE0 &&
    psRegNum <= 8'h0a;
  wire logic badRead = psRdEn && (psRegNum == 8'h04 || psRegNum > 8'h0a ||
    psRegNum < 8'h02);
  // ==========================================================
  // Shadow copies; an OTP load wins over a software write
  // ==========================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrlShadow <= 32'h0;
      secShadow <= 32'h0;
    end
    else
    begin
      if (ctrlWrite)
        ctrlShadow <= psWrData & TCS_TILE_CONTROL_MASK;
      if (otpSecLoad)
        secShadow <= otpSecWord & TCS_SECURITY_MASK;
      else if (secWrite && !secShadow[TCS_WRLOCK_BIT])
        secShadow <= psWrData & TCS_SECURITY_MASK;
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_ack_follows: assert property ((psRdEn || psWrEn) |=> psAck)
    else $error("request got no answer");
  chk_ctrl_outputs: assert property (
    {rgmiiPortEn, utmiSelect, ulpiHelperEn} ==
    {ctrlShadow[8], ctrlShadow[2], ctrlShadow[1]})
    else $error("control outputs wrong");
  chk_low_power: assert property (
    lowPowerDivActive == (ctrlShadow[4] && (!ctrlShadow[5] || allThreadsPaused)))
    else $error("low power state wrong");
  chk_sec_debug: assert property (
    {globalDebugBlock, jtagTapBlock, jtagConfigBlock} ==
    {secShadow[14], secShadow[0], secShadow[4]})
    else $error("debug blocks wrong");
  chk_sec_otp: assert property (
    otpSectorLock == (secShadow[11:8] | {4{secShadow[12]}}) &&
    otpRedundancyEn == secShadow[7] && bootImageFromOtp == secShadow[5])
    else $error("otp controls wrong");
  chk_locked_refused: assert property (
    secWrite && secShadow[31] && !otpSecLoad |=> psAck && psErr)
    else $error("locked write not refused");
  chk_boot_readonly: assert property (
    plainWr && psRegNum == TCS_REG_BOOT_STATUS |=> psAck && psErr)
    else $error("boot write not refused");
  chk_boot_fields: assert property (
    psRdEn && psRegNum == TCS_REG_BOOT_STATUS |=> psRdData == {8'h00,
    $past(procNum), 7'h00, $past(bootStrapOverride), 2'h0,
    $past(core1PoweredOff), $past(skipOtpPoll), $past(bootFromRam),
    $past(bootFromJtag), $past(pllModePins)} && !psErr)
    else $error("boot status fields wrong");
  chk_ring_reserved: assert property (
    ringRead |=> psRdData[31:16] == 16'h0000 && !psErr)
    else $error("counter upper bits set");
  chk_unmapped_read: assert property (
    badRead |=> psErr && psRdData == 32'h0)
    else $error("unmapped read not refused");
endmodule : tcs_regs_props

bind tcs_regs tcs_regs_props tcs_regs_props_inst (.*);

// ==== test/tcs_core_model.sv ====
// Model of the core issuing status register reads and writes.
// Assumes the bench calls access back to back and idle to finish.
module tcs_core_model
(
  // Clock
  input wire logic clk,
  // Status register port
  output logic psWrEn,
  output logic psRdEn,
  output logic [7:0] psRegNum,
  output logic [31:0] psWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial
  begin
    {psWrEn, psRdEn, psRegNum, psWrData} = '0;
  end
  // One request per cycle, launched on the falling edge
  task automatic access(input logic wr, input logic rd,
    input logic [7:0] num, input logic [31:0] data);
    @(negedge clk);
    psWrEn = wr;
    psRdEn = rd;
    psRegNum = num;
    psWrData = data;
  endtask : access
  // Release; stale address and data inverted
  task automatic idle();
    @(negedge clk);
    psWrEn = 1'b0;
    psRdEn = 1'b0;
    psRegNum = ~psRegNum;
    psWrData = ~psWrData;
  endtask : idle
endmodule : tcs_core_model

// ==== test/tcs_regs_bench.sv ====
// Self-checking bench for the tile control and status register bank.
// Assumes tcs_core_model drives the port and the checker is bound.
module tcs_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcs_pkg::*;
  typedef struct packed
  {
    logic [31:0] data;
    logic [31:0] mask;
    logic err;
  } tcs_exp_type;
  tcs_exp_type expQ[$];
  tcs_exp_type expNow;
  int n_fail = 0;
  int checked = 0;
  int seed = 32'hbb75;
  logic clk, resetn, psWrEn, psRdEn, psAck, psErr, txClk, rgmiiPortEn;
  logic [7:0] psRegNum, procNum;
  logic [31:0] psWrData, psRdData, otpSecWord, val;
  logic bootStrapOverride, core1PoweredOff, skipOtpPoll, bootFromRam;
  logic bootFromJtag, otpSecLoad, allThreadsPaused, lowPowerDivActive;
  logic utmiSelect, ulpiHelperEn, globalDebugBlock, jtagTapBlock;
  logic otpRedundancyEn, bootImageFromOtp, jtagConfigBlock;
  logic [1:0] pllModePins;
  logic [3:0] otpSectorLock;
  logic [TCS_TXDATA_WIDTH-1:0] txDataIn, txDataOut;
  logic [TCS_TXDATA_WIDTH-1:0] hist[$];
  logic [15:0] ringA[4], ringB[4], ringC[4];
  logic [8:0] divs[3] = '{9'h002, 9'h005, 9'h010};
  logic [7:0] dly[3] = '{8'h00, 8'h01, 8'hc8};
  tcs_regs tcs_regs_inst (.*);
  tcs_core_model tcs_core_model_inst (.*);
  // ==========================================================
  // Clock, checking and closing
  // ==========================================================
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Each answer is matched against the oldest note
  always @(posedge clk)
  begin
    #1;
    if (psAck === 1'b1)
    begin
      if (expQ.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        expNow = expQ.pop_front();
        check(psRdData & expNow.mask, expNow.data & expNow.mask);
        check({31'h0, psErr}, {31'h0, expNow.err});
      end
    end
  end
  // ==========================================================
  // Request helpers
  // ==========================================================
  task automatic wr(input logic [7:0] num, input logic [31:0] d,
    input logic err);
    expQ.push_back('{32'h0, 32'h0, err});
    tcs_core_model_inst.access(1'b1, 1'b0, num, d);
  endtask : wr
  task automatic rd(input logic [7:0] num, input logic [31:0] d,
    input logic [31:0] m, input logic err);
    expQ.push_back('{d, m, err});
    tcs_core_model_inst.access(1'b0, 1'b1, num, 32'h0);
  endtask : rd
  function automatic logic [31:0] boot_word();
    return {8'h00, procNum, 7'h00, bootStrapOverride, 2'h0, core1PoweredOff,
      skipOtpPoll, bootFromRam, bootFromJtag, pllModePins};
  endfunction : boot_word
  task automatic otp_load(input logic [31:0] w);
    @(negedge clk);
    otpSecLoad = 1'b1;
    otpSecWord = w;
    @(negedge clk);
    otpSecLoad = 1'b0;
  endtask : otp_load
  task automatic reset_pulse();
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
  endtask : reset_pulse
  // Bounded wait for a txClk level
  task automatic wait_level(input logic lvl);
    for (int n = 0; txClk !== lvl; n++)
    begin
      if (n > 600)
      begin
        n_fail++;
        stop_test();
      end
      @(negedge clk);
    end
  endtask : wait_level
  task automatic measure(input logic [8:0] div);
    int hi = 1;
    int per = 1;
    wait_level(1'b0);
    wait_level(1'b1);
    @(negedge clk);
    for (int n = 0; n < 600 && !(txClk === 1'b1 && hi < per); n++)
    begin
      per++;
      hi += (txClk === 1'b1);
      @(negedge clk);
    end
    check(32'(per), 32'(div) + 32'h1);
    check(32'(hi), 32'(div >> 1) + 32'h1);
  endtask : measure
  task automatic idle();
    tcs_core_model_inst.idle();
  endtask : idle
  task automatic read_ring(output logic [15:0] v[4]);
    for (int i = 0; i < 4; i++)
    begin
      rd(TCS_REG_RING_VALUE0 + 8'(i), 32'h0, 32'hffff_0000, 1'b0);
      idle();
      v[i] = psRdData[15:0];
    end
  endtask : read_ring
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    {otpSecLoad, otpSecWord, allThreadsPaused, txDataIn} = '0;
    {procNum, bootStrapOverride, core1PoweredOff, skipOtpPoll, bootFromRam,
      bootFromJtag, pllModePins} = 15'($random(seed));
    reset_pulse();
    // Reset values, unmapped, read-only
    rd(TCS_REG_TILE_CONTROL, 32'h0, '1, 1'b0);
    rd(TCS_REG_SECURITY, 32'h0, '1, 1'b0);
    rd(TCS_REG_RING_CONTROL, 32'h0, '1, 1'b0);
    rd(8'h04, 32'h0, '1, 1'b1);
    rd(8'h0b, 32'h0, '1, 1'b1);
    wr(8'h07, 32'hffff_ffff, 1'b1);
    idle();
    repeat (3)
    begin
      {procNum, bootStrapOverride, core1PoweredOff, skipOtpPoll, bootFromRam,
        bootFromJtag, pllModePins} = 15'($random(seed));
      rd(TCS_REG_BOOT_STATUS, boot_word(), '1, 1'b0);
      wr(TCS_REG_BOOT_STATUS, $random(seed), 1'b1);
      idle();
    end
    // Divider modes, then random control words
    for (int m = 0; m < 8; m++)
    begin
      allThreadsPaused = m[0];
      wr(TCS_REG_TILE_CONTROL, {26'h0, 2'(m >> 1), 4'h0}, 1'b0);
      idle();
    end
    repeat (8)
    begin
      val = $random(seed);
      allThreadsPaused = val[3];
      wr(TCS_REG_TILE_CONTROL, val, 1'b0);
      rd(TCS_REG_TILE_CONTROL, val & TCS_TILE_CONTROL_MASK, '1, 1'b0);
    end
    idle();
    // Security: OTP copy, writes, lock, refused write
    val = $random(seed) & 32'h7fff_ffff;
    otp_load(val);
    rd(TCS_REG_SECURITY, val & TCS_SECURITY_MASK, '1, 1'b0);
    wr(TCS_REG_SECURITY, 32'h7fff_ffff, 1'b0);
    rd(TCS_REG_SECURITY, TCS_SECURITY_MASK & 32'h7fff_ffff, '1, 1'b0);
    wr(TCS_REG_SECURITY, 32'hffff_ffff, 1'b0);
    wr(TCS_REG_SECURITY, 32'h0, 1'b1);
    rd(TCS_REG_SECURITY, TCS_SECURITY_MASK, '1, 1'b0);
    idle();
    // Divider written as ratio minus one
    foreach (divs[i])
    begin
      wr(TCS_REG_TILE_CONTROL, {14'h0, divs[i], 9'h100}, 1'b0);
      idle();
      measure(divs[i]);
    end
    // Transmit data delay
    foreach (dly[i])
    begin
      wr(TCS_REG_TILE_CONTROL, {6'h0, dly[i], 9'h003, 9'h100}, 1'b0);
      idle();
      hist = {};
      repeat (int'(dly[i]) + 30)
      begin
        txDataIn = TCS_TXDATA_WIDTH'($random(seed));
        @(posedge clk);
        hist.push_back(txDataIn);
        @(negedge clk);
        if (hist.size() > int'(dly[i]) + 2)
          check(32'(txDataOut), 32'(hist[hist.size() - 1 - dly[i]]));
      end
    end
    wr(TCS_REG_TILE_CONTROL, 32'h0, 1'b0);
    idle();
    repeat (3) @(negedge clk);
    check({26'h0, txClk, txDataOut}, 32'h0);
    // Ring counters: run all, then core side only
    wr(TCS_REG_RING_CONTROL, 32'h3, 1'b0);
    rd(TCS_REG_RING_CONTROL, 32'h3, '1, 1'b0);
    wr(TCS_REG_RING_CONTROL, 32'h0, 1'b0);
    idle();
    repeat (12) @(negedge clk);
    read_ring(ringA);
    wr(TCS_REG_RING_CONTROL, 32'h2, 1'b0);
    idle();
    repeat (20) @(negedge clk);
    wr(TCS_REG_RING_CONTROL, 32'h0, 1'b0);
    idle();
    repeat (12) @(negedge clk);
    read_ring(ringB);
    for (int i = 0; i < 4; i++)
      check({31'h0, ringB[i] !== ringA[i]}, {31'h0, i < 2});
    // Second reset: counters kept, lock cleared
    reset_pulse();
    rd(TCS_REG_SECURITY, 32'h0, '1, 1'b0);
    idle();
    read_ring(ringC);
    for (int i = 0; i < 4; i++)
      check(32'(ringC[i]), 32'(ringB[i]));
    repeat (3) @(negedge clk);
    check(32'(expQ.size()), 32'h0);
    stop_test();
  end
endmodule : tcs_regs_bench
